// File: hw/vtpc_pkg.sv
// package: register map, field layout and reset values of the pattern control block
package vtpc_pkg;
  // register byte addresses (printed offsets are not multiples of four, so index times four)
  localparam logic [7:0] VTPC_IDX_CTL = 8'h01;
  localparam logic [7:0] VTPC_IDX_CFG = 8'h02;
  localparam logic [7:0] VTPC_IDX_STAT = 8'h03;
  localparam logic [11:0] VTPC_ADDR_CTL = {2'h0, VTPC_IDX_CTL, 2'h0};
  localparam logic [11:0] VTPC_ADDR_CFG = {2'h0, VTPC_IDX_CFG, 2'h0};
  localparam logic [11:0] VTPC_ADDR_STAT = {2'h0, VTPC_IDX_STAT, 2'h0};
  // field positions
  localparam int VTPC_RUN_BIT = 0;
  localparam int VTPC_FIXED_BIT = 7;
  localparam int VTPC_BARS_LO = 4;
  localparam int VTPC_BLK_LO = 0;
  // reset values
  localparam logic [7:0] VTPC_CTL_RESET = 8'h00;
  localparam logic [7:0] VTPC_CFG_RESET = 8'h33;
  // writable bit masks; reserved bits read zero
  localparam logic [7:0] VTPC_CTL_MASK = 8'h01;
  localparam logic [7:0] VTPC_CFG_MASK = 8'hbf;
  // default pattern geometry
  localparam logic [15:0] VTPC_LINE_BYTES = 16'h0780;
  localparam logic [15:0] VTPC_BAR_BYTES = 16'h00f0;
  // byte source states
  typedef enum logic [1:0] {
    VTPC_IDLE = 2'b01,
    VTPC_RUN = 2'b10
  } vtpc_state_t;
endpackage : vtpc_pkg

// File: hw/vtpc_skid.sv
// two-entry buffer between the byte source and the pattern output
`timescale 1ns/1ps
module vtpc_skid #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [2]; // two entries
  logic wr_ptr; // next write slot
  logic rd_ptr; // next read slot
  logic [1:0] count; // words held

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];

  // pointers and occupancy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end
    else
    begin
      if (in_valid && in_ready)
        wr_ptr <= ~wr_ptr;
      if (out_valid && out_ready)
        rd_ptr <= ~rd_ptr;
      // simultaneous push and pop leaves count unchanged
      case ({in_valid && in_ready, out_valid && out_ready})
        2'b10: count <= count + 2'h1;
        2'b01: count <= count - 2'h1;
        default: count <= count;
      endcase
    end
  end

  // storage, no reset needed on data
  always_ff @(posedge pclk)
  begin
    if (in_valid && in_ready)
      mem[wr_ptr] <= in_data;
  end
endmodule : vtpc_skid

// File: hw/vtpc_top.sv
// pattern generator control: apb registers and a simple byte pattern source
// Function
// - generator starts when run bit set, stops at the next line end after it clears
// - config bit 7 picks bars or fixed
// - bar count field selects 1,2,4,8 bars
// - block size field sets fixed field bytes
// - config register resets to 0x33
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module vtpc_top
  import vtpc_pkg::*;
#(
  parameter logic [15:0] LINE_BYTES = VTPC_LINE_BYTES,
  parameter logic [15:0] BAR_BYTES = VTPC_BAR_BYTES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pattern byte stream toward the output path
  output logic pat_valid,
  input wire logic pat_ready,
  output logic [7:0] pat_data,
  output logic pat_line_end,
  // decoded settings
  output logic pattern_run_bit,
  output logic fixed_colour_select,
  output logic [1:0] bar_count_field,
  output logic [3:0] block_size
);
  logic [7:0] pattern_generator_control; // run bit only
  logic [7:0] pattern_generator_config; // mode, bars, block size
  vtpc_state_t state; // byte source state
  vtpc_state_t next_state; // next byte source state
  logic [15:0] byte_cnt; // byte position in line
  logic [15:0] seg_cnt; // byte position inside current bar or block
  logic [15:0] seg_len; // length of current bar or block
  logic last_bar; // final bar, stretched to line end
  logic [3:0] colour; // current bar or block colour index
  logic [3:0] bars_total; // decoded bar count
  logic src_valid; // source offers a byte
  logic src_ready; // buffer accepts a byte
  logic [8:0] src_word; // byte plus line end flag
  logic [8:0] buf_word; // buffered word
  logic acc_wr; // apb write at access end
  logic last_byte; // last byte of the line
  logic seg_end; // last byte of bar or block

  // apb answers in the access cycle, no wait states
  assign pready = 1'b1;
  assign acc_wr = psel && penable && pwrite;

  // unmapped addresses flag an error
  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable && (paddr != VTPC_ADDR_CTL) && (paddr != VTPC_ADDR_CFG) && (paddr != VTPC_ADDR_STAT))
      pslverr = 1'b1;
  end

  // control register write, reserved bits held zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pattern_generator_control <= VTPC_CTL_RESET;
    else if (acc_wr && paddr == VTPC_ADDR_CTL && pstrb[0])
      pattern_generator_control <= pwdata[7:0] & VTPC_CTL_MASK;
  end

  // config register write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pattern_generator_config <= VTPC_CFG_RESET;
    else if (acc_wr && paddr == VTPC_ADDR_CFG && pstrb[0])
      // zero size not guarded, software keeps it legal
      pattern_generator_config <= pwdata[7:0] & VTPC_CFG_MASK;
  end

  // read data registered at setup so it stands through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        VTPC_ADDR_CTL: prdata <= {24'h00_0000, pattern_generator_control};
        VTPC_ADDR_CFG: prdata <= {24'h00_0000, pattern_generator_config};
        // status: running state and current colour index
        VTPC_ADDR_STAT: prdata <= {27'h000_0000, colour, state == VTPC_RUN};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // field decode
  assign pattern_run_bit = pattern_generator_control[VTPC_RUN_BIT];
  assign fixed_colour_select = pattern_generator_config[VTPC_FIXED_BIT];
  assign bar_count_field = pattern_generator_config[VTPC_BARS_LO +: 2];
  assign block_size = pattern_generator_config[VTPC_BLK_LO +: 4];

  always_comb
  begin
    case (bar_count_field)
      2'b00: bars_total = 4'h1;
      2'b01: bars_total = 4'h2;
      2'b10: bars_total = 4'h4;
      default: bars_total = 4'h8;
    endcase
  end

  // state machine of the byte source
  always_comb
  begin
    case (state)
      VTPC_IDLE: next_state = pattern_run_bit ? VTPC_RUN : VTPC_IDLE;
      // stop at line end once run bit cleared
      VTPC_RUN: next_state = (!pattern_run_bit && src_ready && last_byte) ? VTPC_IDLE : VTPC_RUN;
      default: next_state = VTPC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= VTPC_IDLE;
    else
      state <= next_state;
  end

  assign src_valid = (state == VTPC_RUN);
  assign last_byte = (byte_cnt == LINE_BYTES - 16'h0001);
  // fixed mode segment is block size
  assign seg_len = fixed_colour_select ? {12'h000, block_size} : BAR_BYTES;
  assign last_bar = !fixed_colour_select && (colour == bars_total - 4'h1);
  // position counts from zero, so a one-byte block still advances
  assign seg_end = !last_bar && (seg_cnt == seg_len - 16'h0001);
  assign src_word = {last_byte, 4'h0, colour};

  // position, segment and colour counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      byte_cnt <= 16'h0000;
      seg_cnt <= 16'h0000;
      colour <= 4'h0;
    end
    else if (state == VTPC_IDLE)
    begin
      byte_cnt <= 16'h0000;
      seg_cnt <= 16'h0000;
      colour <= 4'h0;
    end
    else if (src_ready)
    begin
      if (last_byte)
      begin
        // line done: next line restarts at first colour
        byte_cnt <= 16'h0000;
        seg_cnt <= 16'h0000;
        colour <= 4'h0;
      end
      else if (seg_end)
      begin
        // next bar or next block
        // fixed blocks wrap through sixteen colour indices
        byte_cnt <= byte_cnt + 16'h0001;
        seg_cnt <= 16'h0000;
        colour <= colour + 4'h1;
      end
      else
      begin
        // inside a segment
        byte_cnt <= byte_cnt + 16'h0001;
        seg_cnt <= seg_cnt + 16'h0001;
      end
    end
  end

  // buffer so a stall downstream loses no byte
  vtpc_skid #(.WIDTH(9)) vtpc_skid_i (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(src_valid),
    .in_ready(src_ready),
    .in_data(src_word),
    .out_valid(pat_valid),
    .out_ready(pat_ready),
    .out_data(buf_word)
  );

  assign pat_data = buf_word[7:0];
  assign pat_line_end = buf_word[8];
endmodule : vtpc_top

// File: dv/vtpc_chk.sv
// checker: register field behaviour seen at the top ports
`timescale 1ns/1ps
module vtpc_chk
  import vtpc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb request side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // stream and fields
  input wire logic pat_valid,
  input wire logic pattern_run_bit,
  input wire logic fixed_colour_select,
  input wire logic [1:0] bar_count_field,
  input wire logic [3:0] block_size
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write strobes; lane 0 carries the 8-bit register
  wire wr_any = psel && penable && pwrite && pstrb[0];
  wire ctl_wr = wr_any && paddr == VTPC_ADDR_CTL;
  wire cfg_wr = wr_any && paddr == VTPC_ADDR_CFG;
  reset_value_a: assert property (
    $rose(presetn) |-> {fixed_colour_select, bar_count_field, block_size, pattern_run_bit} == 8'h66)
    else $error("fields not at reset value");
  run_write_a: assert property (
    ctl_wr |=> pattern_run_bit == $past(pwdata[0])) else $error("run bit not written");
  idle_quiet_a: assert property (
    !pattern_run_bit && !pat_valid |=> !pat_valid) else $error("stream while stopped");
  mode_write_a: assert property (
    cfg_wr |=> fixed_colour_select == $past(pwdata[7])) else $error("mode bit not written");
  bars_write_a: assert property (
    cfg_wr |=> bar_count_field == $past(pwdata[5:4])) else $error("bar count not written");
  block_write_a: assert property (
    cfg_wr |=> block_size == $past(pwdata[3:0])) else $error("block size not written");
  fields_hold_a: assert property (
    !wr_any |=> $stable({fixed_colour_select, bar_count_field, block_size, pattern_run_bit}))
    else $error("fields changed without write");
endmodule : vtpc_chk

bind vtpc_top vtpc_chk vtpc_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .pat_valid, .pattern_run_bit, .fixed_colour_select, .bar_count_field, .block_size);

// File: dv/vtpc_sink.sv
// partner: output path sink that stalls at random and counts lines
`timescale 1ns/1ps
module vtpc_sink #(
  parameter int LINE = 16
) (
  // clock
  input wire logic pclk,
  // pattern stream
  input wire logic pat_valid,
  input wire logic [7:0] pat_data,
  input wire logic pat_line_end,
  output logic pat_ready
);
  int n_bytes = 0; // accepted bytes
  int n_lines = 0; // accepted line ends
  int n_bad = 0; // misplaced line ends
  initial pat_ready = 1'b0;
  // accept and stall about a quarter of cycles to exercise the buffer
  always @(posedge pclk)
  begin
    if (pat_valid === 1'b1 && pat_ready)
    begin
      if (pat_line_end !== (((n_bytes + 1) % LINE) == 0))
        n_bad++;
      n_bytes++;
      n_lines += int'(pat_line_end === 1'b1);
    end
    pat_ready <= ($urandom_range(3) != 0);
  end
endmodule : vtpc_sink

// File: dv/tb_top.sv
// testbench: apb register checks and pattern stream runs
`timescale 1ns/1ps
module tb_top;
  import vtpc_pkg::*;
  localparam int LINE = 16;
  localparam int BAR = 2; // short bars so all bar codes differ in a line
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, pat_valid, pat_ready, pat_line_end, fixed_colour_select, pattern_run_bit;
  logic [7:0] pat_data, cfg;
  logic [1:0] bar_count_field;
  logic [3:0] block_size;
  int n_fail = 0, compares = 0;
  always #5 pclk = ~pclk;
  logic [7:0] cur_cfg = 8'h33; // setting of the running stream
  int pos = 0; // byte position in line
  vtpc_top #(.LINE_BYTES(16'(LINE)), .BAR_BYTES(16'(BAR))) vtpc_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pat_valid(pat_valid), .pat_ready(pat_ready), .pat_data(pat_data), .pat_line_end(pat_line_end),
    .pattern_run_bit(pattern_run_bit), .fixed_colour_select(fixed_colour_select),
    .bar_count_field(bar_count_field), .block_size(block_size)
  );
  vtpc_sink #(.LINE(LINE)) vtpc_sink_i (
    .pclk(pclk), .pat_valid(pat_valid), .pat_data(pat_data), .pat_line_end(pat_line_end),
    .pat_ready(pat_ready)
  );
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: %s", $time, m);
    end
  endtask : chk
  // reserved bit 6 reads back as zero
  function automatic logic [31:0] exp_cfg(input logic [7:0] c);
    return {24'h0, c & 8'hbf};
  endfunction : exp_cfg
  // colour index of a byte position: bars capped at the last bar, blocks counted
  function automatic logic [3:0] exp_colour(input int p, input logic [7:0] c);
    int idx;
    if (c[7])
      idx = p / int'(c[3:0]);
    else
    begin
      idx = p / BAR;
      if (idx > (1 << c[5:4]) - 1)
        idx = (1 << c[5:4]) - 1;
    end
    return idx[3:0];
  endfunction : exp_colour
  // every accepted byte carries the colour of its bar or block
  always @(posedge pclk)
  begin
    if (pat_valid === 1'b1 && pat_ready === 1'b1)
    begin
      chk({24'h0, pat_data}, {28'h0, exp_colour(pos, cur_cfg)}, "colour index");
      pos = (pos + 1) % LINE;
    end
  end
  // run lines in one mode, then stop and see the line finish whole
  task automatic stream(input logic [7:0] c);
    int t;
    int start;
    t = 0;
    start = vtpc_sink_i.n_lines;
    cur_cfg = c;
    apb(1'b1, VTPC_ADDR_CFG, {24'h0, c});
    apb(1'b1, VTPC_ADDR_CTL, 32'h1);
    while (vtpc_sink_i.n_lines < start + 3 && t < 2000)
    begin
      @(posedge pclk);
      t++;
    end
    apb(1'b1, VTPC_ADDR_CTL, 32'h0);
    repeat (100) @(posedge pclk);
    chk({31'h0, vtpc_sink_i.n_lines >= start + 3}, 32'h1, "no lines produced");
    chk(vtpc_sink_i.n_bytes, vtpc_sink_i.n_lines * LINE, "line not whole");
    chk(vtpc_sink_i.n_bad, 0, "line end misplaced");
    chk({31'h0, pat_valid}, 32'h0, "stream after stop");
  endtask : stream
  task automatic final_report;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // watchdog, generous against a few thousand cycles of tests
  initial
  begin
    #300000;
    n_fail++;
    final_report();
  end
  initial
  begin
    rd = $urandom(32'h8262d65b);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, VTPC_ADDR_CTL, 32'h0);
    chk(rd, 32'h0, "ctl reset");
    apb(1'b0, VTPC_ADDR_CFG, 32'h0);
    chk(rd, 32'h33, "cfg reset");
    chk({31'h0, pat_valid}, 32'h0, "stream while off");
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped no error");
    chk(rd, 32'h0, "unmapped data");
    // lane 0 strobe low: write ignored
    pstrb <= 4'he;
    apb(1'b1, VTPC_ADDR_CTL, 32'h1);
    pstrb <= 4'hf;
    apb(1'b0, VTPC_ADDR_CTL, 32'h0);
    chk(rd, 32'h0, "write without strobe");
    // every mode and bar code, random block size
    for (int i = 0; i < 8; i++)
    begin
      // block size kept within 1 to 15
      cfg = {i[2], 1'($urandom_range(1)), i[1:0], 4'($urandom_range(15, 1))};
      apb(1'b1, VTPC_ADDR_CFG, {24'h0, cfg});
      apb(1'b0, VTPC_ADDR_CFG, 32'h0);
      chk(rd, exp_cfg(cfg), "cfg readback");
      chk({24'h0, fixed_colour_select, 1'b0, bar_count_field, block_size}, exp_cfg(cfg), "fields");
    end
    stream(8'h33);
    stream(8'h85);
    // every bar code, then one-byte, widest and random blocks
    for (int i = 0; i < 4; i++)
      stream({2'b00, i[1:0], 4'($urandom_range(15, 1))});
    stream(8'h81);
    stream(8'h8f);
    stream({4'h8, 4'($urandom_range(15, 1))});
    final_report();
  end
endmodule : tb_top
